// *** rtl/ple_engine.v ***
// Summary of operation
// - Evaluate entries in order, stop at end
// - 512 entries, all reset to end marker
// - Disabled element flags stay at zero
// - Constant on and off operands exist
// - 32 identical timers usable in equations
// - Timer pickup delay, zero means immediate
// - Timer dropout delay, zero means immediate
// - Timer type selects counting unit
// - Operating signal is plus minus minus
// - No input selected, never asserts
// - Mismatched input types, never operates
// - Signed uses difference, absolute uses magnitude
// - Level mode or rate over interval
// - Over picks above, under picks below
// - Dropout band is percent of pickup
// - Negative signals and thresholds compared signed
// - Fixed bases for frequency, angle, pf, rtd
// - Current, voltage, power, transducer use max
// - Comparator pickup and reset delays
// - 16 latches restored from nonvolatile image
// - Set/reset table with dominance, off complement
// - Full pass well within quarter cycle
`include "ple_consts.vh"
`default_nettype none
module ple_engine
#(
	parameter MS_CYCLES = `PLE_MS_NS / `PLE_CLK_NS
)
(
	input  wire                        clk,
	input  wire                        rst,
	input  wire                        scan_start,
	input  wire                        eq_wr_en,
	input  wire [`PLE_EQ_AW-1:0]       eq_wr_addr,
	input  wire [`PLE_EQ_DW-1:0]       eq_wr_data,
	input  wire [`PLE_N_OPS-1:0]       ext_operand,
	input  wire [`PLE_N_TMR-1:0]       tmr_enable,
	input  wire [2*`PLE_N_TMR-1:0]     tmr_unit,
	input  wire [16*`PLE_N_TMR-1:0]    tmr_pickup,
	input  wire [16*`PLE_N_TMR-1:0]    tmr_dropout,
	input  wire [16*`PLE_N_MEAS-1:0]   meas_value,
	input  wire [3*`PLE_N_MEAS-1:0]    meas_type,
	input  wire [16*`PLE_N_MEAS-1:0]   meas_nom,
	input  wire [`PLE_N_CMP-1:0]       cmp_enable,
	input  wire [5*`PLE_N_CMP-1:0]     cmp_plus_source,
	input  wire [5*`PLE_N_CMP-1:0]     cmp_minus_source,
	input  wire [`PLE_N_CMP-1:0]       cmp_sign_handling,
	input  wire [`PLE_N_CMP-1:0]       cmp_level_or_rate,
	input  wire [`PLE_N_CMP-1:0]       cmp_over_under_select,
	input  wire [16*`PLE_N_CMP-1:0]    cmp_threshold,
	input  wire [7*`PLE_N_CMP-1:0]     cmp_band_percent,
	input  wire [2*`PLE_N_CMP-1:0]     cmp_interval_unit,
	input  wire [16*`PLE_N_CMP-1:0]    cmp_interval_length,
	input  wire [16*`PLE_N_CMP-1:0]    cmp_assert_delay,
	input  wire [16*`PLE_N_CMP-1:0]    cmp_clear_delay,
	input  wire [`PLE_N_LAT-1:0]       lat_set_dominant,
	input  wire [`PLE_N_LAT-1:0]       lat_restore,
	output wire                        eq_ready,
	output wire                        pass_busy,
	output reg                         pass_done_q,
	output reg  [`PLE_N_OPS-1:0]       virt_out_q,
	output wire [`PLE_N_TMR-1:0]       tmr_out,
	output wire [`PLE_N_CMP-1:0]       cmp_op,
	output reg  [`PLE_N_LAT-1:0]       lat_on_q,
	output wire [`PLE_N_LAT-1:0]       lat_off
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam [3:0] ST_INIT  = 4'h1;
	localparam [3:0] ST_IDLE  = 4'h2;
	localparam [3:0] ST_FETCH = 4'h4;
	localparam [3:0] ST_EXEC  = 4'h8;

	reg  [3:0]                 state_q;
	reg  [`PLE_EQ_AW-1:0]      pc_q;
	reg  [`PLE_EQ_AW-1:0]      init_q;
	reg  [15:0]                stack_q;
	reg  [`PLE_N_TMR-1:0]      tmr_in_q;
	reg  [31:0]                ms_cnt_q;
	reg  [9:0]                 s_cnt_q;
	reg  [5:0]                 m_cnt_q;
	reg                        ms_tick_q;
	reg                        s_tick_q;
	reg                        m_tick_q;
	wire [`PLE_EQ_DW-1:0]      entry;
	wire [3:0]                 opc;
	wire [5:0]                 arg;
	wire                       top;
	wire                       nxt;
	wire                       init_wr;

	// ----------------------------------------
	// Equation store and init sweep
	// ----------------------------------------
	assign init_wr = state_q == ST_INIT;

	ple_eq_ram u_ram
	(
		.clk       (clk),
		.wr_en     (init_wr | eq_wr_en),
		.wr_addr   (init_wr ? init_q : eq_wr_addr),
		.wr_data   (init_wr ? `PLE_END_WORD : eq_wr_data),
		.rd_addr   (pc_q),
		.rd_data_q (entry)
	);

	assign opc       = entry[`PLE_OP_MSB:`PLE_OP_LSB];
	assign arg       = entry[5:0];
	assign top       = stack_q[0];
	assign nxt       = stack_q[1];
	assign eq_ready  = state_q != ST_INIT;
	assign pass_busy = (state_q == ST_FETCH) | (state_q == ST_EXEC);
	assign lat_off   = ~lat_on_q;

	// ----------------------------------------
	// Time unit enables
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (rst)
		begin
			ms_cnt_q  <= 32'h0;
			s_cnt_q   <= 10'h0;
			m_cnt_q   <= 6'h0;
			ms_tick_q <= 1'b0;
			s_tick_q  <= 1'b0;
			m_tick_q  <= 1'b0;
		end
		else
		begin
			ms_tick_q <= ms_cnt_q == MS_CYCLES - 1;
			ms_cnt_q  <= (ms_cnt_q == MS_CYCLES - 1) ? 32'h0 : ms_cnt_q + 32'h1;
			s_tick_q  <= 1'b0;
			m_tick_q  <= 1'b0;
			if (ms_tick_q)
			begin
				s_cnt_q <= (s_cnt_q == `PLE_MS_PER_S) ? 10'h0 : s_cnt_q + 10'h1;
				if (s_cnt_q == `PLE_MS_PER_S)
				begin
					s_tick_q <= 1'b1;
					m_cnt_q  <= (m_cnt_q == `PLE_S_PER_MIN) ? 6'h0 : m_cnt_q + 6'h1;
					m_tick_q <= m_cnt_q == `PLE_S_PER_MIN;
				end
			end
		end
	end

	// ----------------------------------------
	// Evaluation sequencer
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (rst)
		begin
			state_q     <= ST_INIT;
			init_q      <= {`PLE_EQ_AW{1'b0}};
			pc_q        <= {`PLE_EQ_AW{1'b0}};
			pass_done_q <= 1'b0;
		end
		else
		begin
			pass_done_q <= 1'b0;
			case (state_q)
			ST_INIT:
			begin
				init_q <= init_q + 9'h1;
				if (init_q == `PLE_EQ_LAST)
					state_q <= ST_IDLE;
			end
			ST_IDLE:
			begin
				pc_q <= {`PLE_EQ_AW{1'b0}};
				if (scan_start)
					state_q <= ST_FETCH;
			end
			ST_FETCH:
				state_q <= ST_EXEC;
			ST_EXEC:
			begin
				if (opc == `PLE_OP_END || pc_q == `PLE_EQ_LAST)
				begin
					state_q     <= ST_IDLE;
					pass_done_q <= 1'b1;
				end
				else
				begin
					pc_q    <= pc_q + 9'h1;
					state_q <= ST_FETCH;
				end
			end
			default:
				state_q <= ST_INIT;
			endcase
		end
	end

	// ----------------------------------------
	// Operand stack, virtual outputs, latches
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (rst)
		begin
			stack_q    <= 16'h0000;
			virt_out_q <= {`PLE_N_OPS{1'b0}};
			tmr_in_q   <= {`PLE_N_TMR{1'b0}};
			lat_on_q   <= lat_restore;
		end
		else if (state_q == ST_IDLE)
			stack_q <= 16'h0000;
		else if (state_q == ST_EXEC)
		begin
			case (opc)
			`PLE_OP_ON:
				stack_q <= {stack_q[14:0], 1'b1};
			`PLE_OP_OFF:
				stack_q <= {stack_q[14:0], 1'b0};
			`PLE_OP_EXT:
				stack_q <= {stack_q[14:0], ext_operand[arg]};
			`PLE_OP_VIRT:
				stack_q <= {stack_q[14:0], virt_out_q[arg]};
			`PLE_OP_CMP:
				stack_q <= {stack_q[14:0], cmp_op[arg[2:0]]};
			`PLE_OP_NOT:
				stack_q <= {stack_q[15:1], ~top};
			`PLE_OP_AND:
				stack_q <= {1'b0, stack_q[15:2], top & nxt};
			`PLE_OP_OR:
				stack_q <= {1'b0, stack_q[15:2], top | nxt};
			`PLE_OP_XOR:
				stack_q <= {1'b0, stack_q[15:2], top ^ nxt};
			`PLE_OP_TMR:
			begin
				tmr_in_q[arg[4:0]] <= top;
				stack_q <= {stack_q[15:1], tmr_out[arg[4:0]]};
			end
			`PLE_OP_LAT:
			begin
				// Reset on top of stack, set just beneath it
				if (nxt & ~top)
					lat_on_q[arg[3:0]] <= 1'b1;
				else if (top & ~nxt)
					lat_on_q[arg[3:0]] <= 1'b0;
				else if (top & nxt)
					lat_on_q[arg[3:0]] <= lat_set_dominant[arg[3:0]];
				stack_q <= {1'b0, stack_q[15:2],
					(nxt & ~top) | (nxt & lat_set_dominant[arg[3:0]]) |
					(~top & lat_on_q[arg[3:0]])};
			end
			`PLE_OP_ASSIGN:
			begin
				virt_out_q[arg] <= top;
				stack_q <= {1'b0, stack_q[15:1]};
			end
			default:
				stack_q <= stack_q;
			endcase
		end
	end

	// ----------------------------------------
	// Delay timers
	// ----------------------------------------
	genvar t;
	generate
		for (t = 0; t < `PLE_N_TMR; t = t + 1)
		begin : g_tmr
			reg  [15:0] cnt_q;
			reg         out_q;
			wire [1:0]  unit = tmr_unit[2*t+:2];
			wire [15:0] pkp  = tmr_pickup[16*t+:16];
			wire [15:0] dpo  = tmr_dropout[16*t+:16];
			wire        tick = (unit == `PLE_UNIT_MS) ? ms_tick_q :
				(unit == `PLE_UNIT_S) ? s_tick_q : m_tick_q;
			wire [15:0] lim  = tmr_in_q[t] ? pkp : dpo;

			// Count while input differs from output
			always @(posedge clk)
			begin
				if (rst || !tmr_enable[t])
				begin
					cnt_q <= 16'h0;
					out_q <= 1'b0;
				end
				else if (tmr_in_q[t] == out_q)
					cnt_q <= 16'h0;
				else if (lim == 16'h0)
					out_q <= tmr_in_q[t];
				else if (tick)
				begin
					cnt_q <= cnt_q + 16'h1;
					if (cnt_q + 16'h1 >= lim)
					begin
						out_q <= tmr_in_q[t];
						cnt_q <= 16'h0;
					end
				end
			end
			assign tmr_out[t] = out_q;
		end
	endgenerate

	// ----------------------------------------
	// Analog comparators
	// ----------------------------------------
	genvar k;
	generate
		for (k = 0; k < `PLE_N_CMP; k = k + 1)
		begin : g_cmp
			reg                raw_q;
			reg                out_q;
			reg  [15:0]        dly_q;
			reg  [15:0]        ivl_q;
			reg  signed [18:0] snap_q;
			reg  signed [18:0] delta_q;
			reg  [15:0]        base;
			wire [4:0]  ps   = cmp_plus_source[5*k+:5];
			wire [4:0]  ms   = cmp_minus_source[5*k+:5];
			wire        p_on = ps != 5'h0;
			wire        m_on = ms != 5'h0;
			wire [3:0]  pi   = ps[3:0] - 4'h1;
			wire [3:0]  mi   = ms[3:0] - 4'h1;
			wire [2:0]  pt   = meas_type[3*pi+:3];
			wire [2:0]  mt   = meas_type[3*mi+:3];
			wire [2:0]  typ  = p_on ? pt : mt;
			wire [15:0] pn   = p_on ? meas_nom[16*pi+:16] : 16'h0;
			wire [15:0] mn   = m_on ? meas_nom[16*mi+:16] : 16'h0;
			wire signed [16:0] pv = p_on ? {meas_value[16*pi+15], meas_value[16*pi+:16]}
				: 17'sh0;
			wire signed [16:0] mv = m_on ? {meas_value[16*mi+15], meas_value[16*mi+:16]}
				: 17'sh0;
			wire signed [17:0] diff = {pv[16], pv} - {mv[16], mv};
			wire signed [18:0] sig  = (cmp_sign_handling[k] && diff < 0) ?
				-{diff[17], diff} : {diff[17], diff};
			wire signed [18:0] dop  = (cmp_sign_handling[k] && delta_q < 0) ?
				-delta_q : delta_q;
			wire signed [18:0] op   = cmp_level_or_rate[k] ? dop : sig;
			wire valid = cmp_enable[k] & (p_on | m_on) & (!(p_on & m_on) | pt == mt);
			wire signed [15:0] thr  = cmp_threshold[16*k+:16];
			wire signed [47:0] lhs  = op * $signed(`PLE_MPU_SCALE) * $signed(`PLE_PCT_SCALE);
			wire signed [47:0] pk   = thr * $signed({1'b0, base}) * $signed(`PLE_PCT_SCALE);
			wire signed [47:0] band = (thr < 0 ? -thr : thr) * $signed({1'b0, base})
				* $signed({1'b0, cmp_band_percent[7*k+:7]});
			wire pick = cmp_over_under_select[k] ? (lhs < pk) : (lhs > pk);
			wire drop = cmp_over_under_select[k] ? (lhs > pk + band) :
				(lhs < pk - band);
			wire        itick = (cmp_interval_unit[2*k+:2] == `PLE_UNIT_MS) ? ms_tick_q :
				(cmp_interval_unit[2*k+:2] == `PLE_UNIT_S) ? s_tick_q : m_tick_q;
			wire [15:0] ilen  = cmp_interval_length[16*k+:16];
			wire [15:0] dlim  = raw_q ? cmp_assert_delay[16*k+:16] :
				cmp_clear_delay[16*k+:16];

			// Per-unit base by measurement type
			always @*
			begin
				case (typ)
				`PLE_MT_FREQ:  base = `PLE_BASE_FREQ;
				`PLE_MT_ANGLE: base = `PLE_BASE_ANGLE;
				`PLE_MT_PF:    base = `PLE_BASE_PF;
				`PLE_MT_RTD:   base = `PLE_BASE_RTD;
				default:       base = (pn > mn) ? pn : mn;
				endcase
			end

			// Rate sampling, level detect with band, output delay
			always @(posedge clk)
			begin
				if (rst || !valid)
				begin
					raw_q   <= 1'b0;
					out_q   <= 1'b0;
					dly_q   <= 16'h0;
					ivl_q   <= 16'h0;
					snap_q  <= 19'sh0;
					delta_q <= 19'sh0;
				end
				else
				begin
					if (itick)
					begin
						ivl_q <= ivl_q + 16'h1;
						if (ivl_q + 16'h1 >= ilen)
						begin
							ivl_q   <= 16'h0;
							snap_q  <= sig;
							delta_q <= sig - snap_q;
						end
					end
					raw_q <= raw_q ? ~drop : pick;
					if (raw_q == out_q)
						dly_q <= 16'h0;
					else if (dlim == 16'h0)
						out_q <= raw_q;
					else if (ms_tick_q)
					begin
						dly_q <= dly_q + 16'h1;
						if (dly_q + 16'h1 >= dlim)
						begin
							out_q <= raw_q;
							dly_q <= 16'h0;
						end
					end
				end
			end
			assign cmp_op[k] = out_q;
		end
	endgenerate
endmodule // ple_engine
`default_nettype wire

// *** rtl/ple_consts.vh ***
`ifndef PLE_CONSTS_VH
`define PLE_CONSTS_VH
// ----------------------------------------
// Equation store geometry
// ----------------------------------------
`define PLE_EQ_DEPTH     512
`define PLE_EQ_AW        9
`define PLE_EQ_DW        16
`define PLE_EQ_LAST      9'h1FF
// Entry layout: opcode in the top nibble, operand index below
`define PLE_OP_MSB       15
`define PLE_OP_LSB       12
`define PLE_ARG_MSB      11
// ----------------------------------------
// Opcodes (all-zero entry is the end marker)
// ----------------------------------------
`define PLE_OP_END       4'h0
`define PLE_OP_ON        4'h1
`define PLE_OP_OFF       4'h2
`define PLE_OP_EXT       4'h3
`define PLE_OP_VIRT      4'h4
`define PLE_OP_CMP       4'h5
`define PLE_OP_NOT       4'h6
`define PLE_OP_AND       4'h7
`define PLE_OP_OR        4'h8
`define PLE_OP_XOR       4'h9
`define PLE_OP_TMR       4'hA
`define PLE_OP_LAT       4'hB
`define PLE_OP_ASSIGN    4'hC
`define PLE_END_WORD     16'h0000
// ----------------------------------------
// Element counts
// ----------------------------------------
`define PLE_N_TMR        32
`define PLE_N_CMP        8
`define PLE_N_LAT        16
`define PLE_N_OPS        64
`define PLE_N_MEAS       16
// ----------------------------------------
// Measurement type codes and fixed bases (values in hundredths)
// ----------------------------------------
`define PLE_MT_FREQ      3'h3
`define PLE_MT_ANGLE     3'h4
`define PLE_MT_PF        3'h5
`define PLE_MT_RTD       3'h6
`define PLE_BASE_FREQ    16'h0064
`define PLE_BASE_ANGLE   16'h8CA0
`define PLE_BASE_PF      16'h0064
`define PLE_BASE_RTD     16'h2710
`define PLE_MPU_SCALE    48'h0000000003E8
`define PLE_PCT_SCALE    48'h000000000064
// ----------------------------------------
// Time base
// ----------------------------------------
`define PLE_CLK_NS       10
`define PLE_MS_NS        1000000
`define PLE_MS_PER_S     10'h3E7
`define PLE_S_PER_MIN    6'h3B
`define PLE_UNIT_MS      2'h0
`define PLE_UNIT_S       2'h1
`endif

// *** rtl/ple_eq_ram.v ***
`default_nettype none
// Equation store: one write port, registered read data
module ple_eq_ram
(
	input  wire                    clk,
	input  wire                    wr_en,
	input  wire [`PLE_EQ_AW-1:0]   wr_addr,
	input  wire [`PLE_EQ_DW-1:0]   wr_data,
	input  wire [`PLE_EQ_AW-1:0]   rd_addr,
	output reg  [`PLE_EQ_DW-1:0]   rd_data_q
);
	reg [`PLE_EQ_DW-1:0] mem [0:`PLE_EQ_DEPTH-1];

	// Write and registered read
	always @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data_q <= mem[rd_addr];
	end
endmodule // ple_eq_ram
`default_nettype wire

// *** bench/ple_engine_assertions.sv ***
`include "ple_consts.vh"
`default_nettype none
// ----------------------------------------
// Port checker for the logic engine
// ----------------------------------------
module ple_chk
(
	input wire logic                        clk,
	input wire logic                        rst,
	input wire logic                        scan_start,
	input wire logic [`PLE_N_TMR-1:0]       tmr_enable,
	input wire logic [`PLE_N_CMP-1:0]       cmp_enable,
	input wire logic [5*`PLE_N_CMP-1:0]     cmp_plus_source,
	input wire logic [5*`PLE_N_CMP-1:0]     cmp_minus_source,
	input wire logic [`PLE_N_LAT-1:0]       lat_restore,
	input wire logic                        eq_ready,
	input wire logic                        pass_busy,
	input wire logic                        pass_done_q,
	input wire logic [`PLE_N_TMR-1:0]       tmr_out,
	input wire logic [`PLE_N_CMP-1:0]       cmp_op,
	input wire logic [`PLE_N_LAT-1:0]       lat_on_q,
	input wire logic [`PLE_N_LAT-1:0]       lat_off
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	// Length of the current pass in busy cycles
	logic [10:0] busy_cnt;
	always_ff @(posedge clk)
	begin
		if (rst || !pass_busy)
			busy_cnt <= 11'h000;
		else
			busy_cnt <= busy_cnt + 11'h001;
	end
	// Start taken, then at least fetch and execute of one entry
	sequence s_take;
		scan_start && !pass_busy && eq_ready;
	endsequence
	sequence s_run;
		pass_busy[*2];
	endsequence
	a_pass_starts: assert property (disable iff (rst)
		s_take |=> s_run)
		else $error("pass did not start after request");
	a_pass_ends: assert property (disable iff (rst)
		busy_cnt <= 11'h400)
		else $error("pass did not end in time");
	a_done_single: assert property (disable iff (rst)
		pass_done_q |=> !pass_done_q)
		else $error("pass done longer than one cycle");
	a_ready_no_busy: assert property (disable iff (rst)
		!eq_ready |-> !pass_busy)
		else $error("pass running before store ready");
	a_rst_not_ready: assert property (rst |=> !eq_ready)
		else $error("store ready right after reset");
	a_rst_restore: assert property (rst |=> lat_on_q == $past(lat_restore))
		else $error("latch image not loaded in reset");
	a_off_compl: assert property (disable iff (rst) lat_off == ~lat_on_q)
		else $error("latch off not complement of on");
	a_tmr_disabled: assert property (disable iff (rst)
		(tmr_out & ~tmr_enable & ~$past(tmr_enable)) == '0)
		else $error("disabled timer output set");
	a_cmp_disabled: assert property (disable iff (rst)
		(cmp_op & ~cmp_enable & ~$past(cmp_enable)) == '0)
		else $error("disabled comparator output set");
	a_cmp_no_input: assert property (disable iff (rst)
		(cmp_plus_source[4:0] == 5'h00 && cmp_minus_source[4:0] == 5'h00)[*3]
		|-> !$rose(cmp_op[0]))
		else $error("comparator rose without inputs");
endmodule // ple_chk

bind ple_engine ple_chk u_chk
(
	.clk, .rst, .scan_start, .tmr_enable, .cmp_enable, .cmp_plus_source,
	.cmp_minus_source, .lat_restore, .eq_ready, .pass_busy, .pass_done_q,
	.tmr_out, .cmp_op, .lat_on_q, .lat_off
);
`default_nettype wire

// *** bench/ple_src_model.sv ***
`include "ple_consts.vh"
`default_nettype none
// ----------------------------------------
// Measurement and operand source model
// ----------------------------------------
module ple_src_model
(
	input  wire logic [1:0]                 ext_sel,
	output logic      [`PLE_N_OPS-1:0]      ext_operand,
	output logic      [16*`PLE_N_MEAS-1:0]  meas_value,
	output logic      [3*`PLE_N_MEAS-1:0]   meas_type,
	output logic      [16*`PLE_N_MEAS-1:0]  meas_nom
);
	timeunit 1ns;
	timeprecision 1ps;
	// Two live operands, the rest held low
	assign ext_operand = {{(`PLE_N_OPS-2){1'b0}}, ext_sel};
	// Two frequencies and one angle, in hundredths
	always_comb
	begin
		meas_value = '0;
		meas_type = '0;
		meas_nom = {`PLE_N_MEAS{16'h0064}};
		meas_value[15:0] = 16'h0096;
		meas_value[31:16] = 16'h0032;
		meas_value[47:32] = 16'h0032;
		meas_type[2:0] = `PLE_MT_FREQ;
		meas_type[5:3] = `PLE_MT_FREQ;
		meas_type[8:6] = `PLE_MT_ANGLE;
	end
endmodule // ple_src_model
`default_nettype wire

// *** bench/ple_engine_bench.sv ***
`include "ple_consts.vh"
`default_nettype none
module ple_engine_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic                       clk, eq_ready, pass_busy, pass_done_q;
	logic                       rst = 1'b1, scan_start = 1'b0, eq_wr_en = 1'b0;
	logic [`PLE_EQ_AW-1:0]      eq_wr_addr = '0;
	logic [`PLE_EQ_DW-1:0]      eq_wr_data = '0;
	logic [1:0]                 ext_sel = 2'h0;
	logic [`PLE_N_OPS-1:0]      ext_operand, virt_out_q;
	logic [`PLE_N_TMR-1:0]      tmr_enable = '0, tmr_out;
	logic [2*`PLE_N_TMR-1:0]    tmr_unit = '0;
	logic [16*`PLE_N_TMR-1:0]   tmr_pickup = '0, tmr_dropout = '0;
	logic [16*`PLE_N_MEAS-1:0]  meas_value, meas_nom;
	logic [3*`PLE_N_MEAS-1:0]   meas_type;
	logic [`PLE_N_CMP-1:0]      cmp_enable = 8'h01, cmp_op;
	logic [`PLE_N_CMP-1:0]      cmp_sign_handling = '0, cmp_level_or_rate = '0;
	logic [`PLE_N_CMP-1:0]      cmp_over_under_select = '0;
	logic [5*`PLE_N_CMP-1:0]    cmp_plus_source = '0, cmp_minus_source = '0;
	logic [16*`PLE_N_CMP-1:0]   cmp_threshold = 128'h1F4, cmp_interval_length = '0;
	logic [16*`PLE_N_CMP-1:0]   cmp_assert_delay = '0, cmp_clear_delay = '0;
	logic [7*`PLE_N_CMP-1:0]    cmp_band_percent = '0;
	logic [2*`PLE_N_CMP-1:0]    cmp_interval_unit = '0;
	logic [`PLE_N_LAT-1:0]      lat_set_dominant = '0, lat_restore = '0;
	logic [`PLE_N_LAT-1:0]      lat_on_q, lat_off;
	int                         mismatches = 0, cmp_count = 0;
	// Engine and its source model
	ple_engine #(.MS_CYCLES(10)) u_dut
	(
		.clk, .rst, .scan_start, .eq_wr_en, .eq_wr_addr, .eq_wr_data, .ext_operand,
		.tmr_enable, .tmr_unit, .tmr_pickup, .tmr_dropout, .meas_value, .meas_type,
		.meas_nom, .cmp_enable, .cmp_plus_source, .cmp_minus_source, .cmp_sign_handling,
		.cmp_level_or_rate, .cmp_over_under_select, .cmp_threshold, .cmp_band_percent,
		.cmp_interval_unit, .cmp_interval_length, .cmp_assert_delay, .cmp_clear_delay,
		.lat_set_dominant, .lat_restore, .eq_ready, .pass_busy, .pass_done_q,
		.virt_out_q, .tmr_out, .cmp_op, .lat_on_q, .lat_off
	);
	ple_src_model u_src (.ext_sel, .ext_operand, .meas_value, .meas_type, .meas_nom);
	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input int a, input logic [15:0] d);
		eq_wr_en = 1'b1;
		eq_wr_addr = a[8:0];
		eq_wr_data = d;
		tick(1);
	endtask
	// One pass; n entries stand before the end marker
	task automatic run_pass(input int n);
		int i;
		scan_start = 1'b1;
		tick(1);
		scan_start = 1'b0;
		for (i = 0; i < 1100 && pass_done_q !== 1'b1; i++)
			tick(1);
		chk(i, 2 * (n + 1), "pass length");
		if (i == 1100)
			end_of_test;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic do_reset(input logic [15:0] img);
		int i;
		lat_restore = img;
		rst = 1'b1;
		tick(8);
		rst = 1'b0;
		chk(lat_on_q, img, "latch image");
		for (i = 0; i < 600 && eq_ready !== 1'b1; i++)
			tick(1);
		chk(i >= 512 && i <= 513, 1'b1, "store sweep length");
		if (i == 600)
			end_of_test;
	endtask
	task automatic t_stop;
		wr(0, 16'h1000);
		wr(1, 16'hC000);
		wr(2, 16'h0000);
		wr(3, 16'h1000);
		wr(4, 16'hC001);
		eq_wr_en = 1'b0;
		run_pass(2);
		chk(virt_out_q[1:0], 2'b01, "stop at end");
		wr(0, 16'h2000);
		eq_wr_en = 1'b0;
		run_pass(2);
		chk(virt_out_q[1:0], 2'b00, "constant off");
	endtask
	// Latch table over both dominance settings
	task automatic t_latch;
		logic st;
		int k;
		st = 1'b1;
		wr(0, 16'h3000);
		wr(1, 16'h3001);
		wr(2, 16'hB000);
		wr(3, 16'hC002);
		wr(4, 16'h0000);
		eq_wr_en = 1'b0;
		for (k = 0; k < 8; k++)
		begin
			lat_set_dominant[0] = k[2];
			ext_sel = {k[0], k[1]};
			st = (k[1] && k[0]) ? k[2] : k[1] ? 1'b1 : k[0] ? 1'b0 : st;
			run_pass(4);
			chk(lat_on_q[0], st, "latch state");
			chk(virt_out_q[2], st, "latch on stack");
		end
	endtask
	// Rows: plus, minus, absolute, under, expected output
	task automatic t_cmp;
		logic [7:0] rows [8];
		int k;
		rows = '{8'h62, 8'h64, 8'h70, 8'h04, 8'h96, 8'h9A, 8'h26, 8'h9C};
		for (k = 0; k < 8; k++)
		begin
			cmp_plus_source[4:0] = {3'h0, rows[k][7:6]};
			cmp_minus_source[4:0] = {3'h0, rows[k][5:4]};
			cmp_sign_handling[0] = rows[k][3];
			cmp_over_under_select[0] = rows[k][2];
			tick(40);
			chk(cmp_op[0], rows[k][1], "comparator");
		end
	endtask
	// Main sequence
	initial
	begin
		do_reset(16'h0001);
		run_pass(0);
		t_stop;
		t_latch;
		t_cmp;
		do_reset(16'h8000);
		end_of_test;
	end
endmodule // ple_engine_bench
`default_nettype wire
